// [logic/lfl_ext_watch.sv]
// watches the shared fault line for a low held by another party
`default_nettype none
module lfl_ext_watch #(
  parameter int CYCLES = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic line_low,
  output logic      held_low
);
  typedef struct packed
  {
    logic [7:0] cnt;
    logic       held;
  } lfl_ext_t;
  lfl_ext_t s_r;
  lfl_ext_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (!line_low)
    begin
      s_nxt.cnt = 8'h00;
      s_nxt.held = 1'b0;
    end
    // the count of low samples has passed CYCLES once this edge sees one more
    else if (s_r.cnt >= 8'(CYCLES))
      s_nxt.held = 1'b1;
    else
      s_nxt.cnt = s_r.cnt + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign held_low = s_r.held;
endmodule
`default_nettype wire

// [logic/lfl_low_if.sv]
// low-period timer request and expiry signals
`default_nettype none
interface lfl_low_if;
  logic level;
  logic expired;
  modport timer (input level, output expired);
  modport user  (output level, input expired);
endinterface
`default_nettype wire

// [logic/lfl_low_timer.sv]
// counts how long an input has been low, pulses once on expiry
`default_nettype none
`include "lfl_params.svh"
module lfl_low_timer #(
  parameter int CYCLES = 400000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  lfl_low_if.timer  lo
);
  typedef struct packed
  {
    logic [31:0] cnt;
    logic        done;
    logic        pulse;
  } lfl_tmr_t;
  lfl_tmr_t s_r;
  lfl_tmr_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    if (lo.level)
    begin
      s_nxt.cnt = 32'h0;
      s_nxt.done = 1'b0;
    end
    else if (!s_r.done)
    begin
      if (s_r.cnt >= 32'(CYCLES))
      begin
        s_nxt.done = 1'b1;
        s_nxt.pulse = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign lo.expired = s_r.pulse;
endmodule
`default_nettype wire

// [logic/lfl_params.svh]
// constants for the led fault latch and shutdown block
`ifndef LFL_PARAMS_SVH
`define LFL_PARAMS_SVH
`define LFL_CLK_HZ          25000000
`define LFL_LOW_TIME_US     16000
`define LFL_LOW_CYCLES      ((`LFL_LOW_TIME_US * (`LFL_CLK_HZ / 1000000)) / 1000 * 1000)
`define LFL_EXT_FAULT_CYC   8
`define LFL_ADDR_CTRL       12'h000
`define LFL_ADDR_STATUS     12'h004
`define LFL_ADDR_IRQ_STAT   12'h008
`define LFL_ADDR_IRQ_MASK   12'h00C
`define LFL_ADDR_SHORTED    12'h010
`define LFL_CTRL_ALL_OFF    0
`define LFL_IRQ_W           4
`define LFL_IRQ_SHORT       0
`define LFL_IRQ_EXT         1
`define LFL_IRQ_SLEEP       2
`define LFL_IRQ_CLEAR       3
`endif

// [logic/lfl_pkg.sv]
// types of the led fault latch and shutdown block
`default_nettype none
package lfl_pkg;
  typedef enum logic [3:0]
  {
    LFL_SLEEP = 4'h1,
    LFL_IDLE  = 4'h2,
    LFL_SOFT  = 4'h4,
    LFL_RUN   = 4'h8
  } lfl_mode_t;
endpackage
`default_nettype wire

// [logic/lfl_top.sv]
// fault latch, sleep and shutdown control of a four channel led driver
`default_nettype none
`include "lfl_params.svh"
module lfl_top #(
  parameter int CHANNELS   = 4,
  parameter int LOW_CYCLES = 400000,
  parameter int SOFT_CYCLES = 256
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                enable_in,
  input  wire logic                dim_in,
  input  wire logic [CHANNELS-1:0] above_short_threshold,
  input  wire logic [CHANNELS-1:0] at_regulation,
  input  wire logic                fault_line_in,
  output logic                     fault_line_out,
  output logic                     fault_line_oe,
  output logic                     bias_on,
  output logic                     sync_clock_output_en,
  output logic                     boost_en,
  output logic [CHANNELS-1:0]      sink_en,
  output logic                     irq
);
  lfl_low_if en_lo ();
  lfl_low_if dim_lo ();
  logic ext_held;
  typedef struct packed
  {
    lfl_pkg::lfl_mode_t          mode;
    logic                        en_d;
    logic [CHANNELS-1:0]         shorted;
    logic                        all_off;
    logic                        ext_off;
    logic                        cfg_all_off;
    logic [15:0]                 soft_cnt;
    logic [`LFL_IRQ_W-1:0]       ist;
    logic [`LFL_IRQ_W-1:0]       imask;
    logic [31:0]                 rdata;
    logic                        ready;
    logic                        slverr;
    logic                        fault_oe;
    logic                        bias;
    logic                        boost;
    logic [CHANNELS-1:0]         sinks;
    logic                        irq;
  } lfl_state_t;
  lfl_state_t s_r;
  lfl_state_t s_nxt;
  ////////////////////////////////////////////////////////////////////////////
  assign en_lo.level  = enable_in;
  assign dim_lo.level = dim_in | ~enable_in;
  lfl_low_timer #(.CYCLES(LOW_CYCLES)) u_en_tmr
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lo      (en_lo)
  );
  lfl_low_timer #(.CYCLES(LOW_CYCLES)) u_dim_tmr
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lo      (dim_lo)
  );
  // line sensed low while we do not drive it means another party pulls it
  lfl_ext_watch #(.CYCLES(`LFL_EXT_FAULT_CYC)) u_ext
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .line_low (~fault_line_in & ~s_r.fault_oe),
    .held_low (ext_held)
  );
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic                  acc;
    logic                  clr_faults;
    logic                  det_on;
    logic [CHANNELS-1:0]   new_short;
    logic [`LFL_IRQ_W-1:0] ev;
    acc = psel & penable;
    clr_faults = 1'b0;
    det_on = 1'b0;
    new_short = '0;
    ev = '0;
    s_nxt = s_r;
    s_nxt.en_d = enable_in;
    s_nxt.ready = 1'b0;
    s_nxt.slverr = 1'b0;
    // mode sequencing
    case (s_r.mode)
      lfl_pkg::LFL_SLEEP:
      begin
        if (enable_in && !s_r.en_d)
        begin
          clr_faults = 1'b1;
          s_nxt.mode = lfl_pkg::LFL_IDLE;
        end
      end
      lfl_pkg::LFL_IDLE:
      begin
        if (dim_in)
        begin
          s_nxt.mode = lfl_pkg::LFL_SOFT;
          s_nxt.soft_cnt = 16'h0000;
        end
      end
      lfl_pkg::LFL_SOFT:
      begin
        if (s_r.soft_cnt >= 16'(SOFT_CYCLES))
          s_nxt.mode = lfl_pkg::LFL_RUN;
        else
          s_nxt.soft_cnt = s_r.soft_cnt + 16'h0001;
      end
      lfl_pkg::LFL_RUN:
      begin
      end
      default:
        s_nxt.mode = lfl_pkg::LFL_SLEEP;
    endcase
    if (en_lo.expired)
    begin
      s_nxt.mode = lfl_pkg::LFL_SLEEP;
      ev[`LFL_IRQ_SLEEP] = 1'b1;
    end
    else if (dim_lo.expired)
    begin
      clr_faults = 1'b1;
      s_nxt.mode = lfl_pkg::LFL_IDLE;
    end
    // short detection, gated by at least one pin in regulation
    det_on = |at_regulation && s_r.mode == lfl_pkg::LFL_RUN;
    if (det_on)
      new_short = above_short_threshold & ~s_r.shorted;
    s_nxt.shorted = s_r.shorted | new_short;
    if (|new_short)
      ev[`LFL_IRQ_SHORT] = 1'b1;
    if (|new_short && s_r.cfg_all_off)
      s_nxt.all_off = 1'b1;
    if (ext_held && s_r.cfg_all_off && !s_r.ext_off)
    begin
      s_nxt.ext_off = 1'b1;
      ev[`LFL_IRQ_EXT] = 1'b1;
    end
    // a fault raised in the clearing cycle itself is kept, so set wins
    if (clr_faults)
    begin
      s_nxt.shorted = new_short;
      s_nxt.ext_off = s_nxt.ext_off & ~s_r.ext_off;
      s_nxt.all_off = s_nxt.all_off & ~s_r.all_off;
      ev[`LFL_IRQ_CLEAR] = 1'b1;
    end
    // register access
    if (acc && !s_r.ready)
    begin
      s_nxt.ready = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      if (paddr == `LFL_ADDR_CTRL)
      begin
        s_nxt.rdata[0] = s_r.cfg_all_off;
        if (pwrite)
          s_nxt.cfg_all_off = pwdata[`LFL_CTRL_ALL_OFF];
      end
      else if (paddr == `LFL_ADDR_STATUS)
        s_nxt.rdata = {24'h00_0000, s_r.ext_off, s_r.all_off, s_r.fault_oe, 1'b0, s_r.mode};
      else if (paddr == `LFL_ADDR_IRQ_STAT)
      begin
        s_nxt.rdata[`LFL_IRQ_W-1:0] = s_r.ist;
        if (pwrite)
          s_nxt.ist = s_r.ist & ~pwdata[`LFL_IRQ_W-1:0];
      end
      else if (paddr == `LFL_ADDR_IRQ_MASK)
      begin
        s_nxt.rdata[`LFL_IRQ_W-1:0] = s_r.imask;
        if (pwrite)
          s_nxt.imask = pwdata[`LFL_IRQ_W-1:0];
      end
      else if (paddr == `LFL_ADDR_SHORTED)
        s_nxt.rdata[CHANNELS-1:0] = s_r.shorted;
      else
        s_nxt.slverr = 1'b1;
    end
    // set wins over a write-one clear in the same cycle
    s_nxt.ist = s_nxt.ist | ev;
    // outputs, all registered
    s_nxt.fault_oe = |s_nxt.shorted | s_nxt.all_off;
    // bias rides through an enable low shorter than the sleep time
    s_nxt.bias = s_nxt.mode != lfl_pkg::LFL_SLEEP;
    s_nxt.boost = dim_in && !s_nxt.all_off && !s_nxt.ext_off &&
                  (s_nxt.mode == lfl_pkg::LFL_SOFT || s_nxt.mode == lfl_pkg::LFL_RUN);
    s_nxt.sinks = (s_nxt.boost && s_nxt.mode == lfl_pkg::LFL_RUN) ?
                  ~s_nxt.shorted : '0;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.mode <= lfl_pkg::LFL_SLEEP;
    end
    else
      s_r <= s_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slverr;
  assign fault_line_out = 1'b0;
  assign fault_line_oe = s_r.fault_oe;
  assign bias_on = s_r.bias;
  assign sync_clock_output_en = s_r.bias;
  assign boost_en = s_r.boost;
  assign sink_en = s_r.sinks;
  assign irq = s_r.irq;
endmodule
`default_nettype wire

// [testbench/lfl_peer_model.sv]
// peer drivers and pull-up on the shared open drain fault line
`default_nettype none
module lfl_peer_model (
  input  wire logic dut_pull,
  input  wire logic peer_pull,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired-and: any party pulls low, the pull-up wins otherwise
  assign line = (dut_pull || peer_pull) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// [testbench/lfl_top_sva.sv]
// assertions on the ports of the fault latch and shutdown block
`default_nettype none
module lfl_top_sva #(
  parameter int CHANNELS   = 4,
  parameter int LOW_CYCLES = 400000
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                enable_in,
  input wire logic                dim_in,
  input wire logic [CHANNELS-1:0] above_short_threshold,
  input wire logic [CHANNELS-1:0] at_regulation,
  input wire logic                fault_line_out,
  input wire logic                fault_line_oe,
  input wire logic                bias_on,
  input wire logic                sync_clock_output_en,
  input wire logic                boost_en,
  input wire logic [CHANNELS-1:0] sink_en
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // counts enable low time; runs are short, so no saturation
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_cnt_r <= 0;
    else
      low_cnt_r <= enable_in ? 0 : low_cnt_r + 1;
  sequence s_short_seen;
    |at_regulation && |(sink_en & above_short_threshold);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_sleep_after_low: assert property (low_cnt_r > LOW_CYCLES + 3 |-> !bias_on)
    else $error("bias still on after long enable low");
  a_sleep_all_off: assert property (!bias_on |-> !boost_en && sink_en == '0)
    else $error("output enabled while asleep");
  a_sink_needs_dim: assert property (|sink_en |-> $past(dim_in))
    else $error("sink on without dimming high");
  a_bias_clock_pair: assert property (bias_on == sync_clock_output_en)
    else $error("bias and clock output differ");
  a_bias_held_on: assert property ($past(enable_in, 2) && $past(enable_in) && enable_in && bias_on |=> bias_on)
    else $error("bias dropped while enabled");
  a_open_drain_low: assert property (fault_line_out == 1'h0)
    else $error("fault line driven high");
  a_short_drop: assert property (s_short_seen |-> ##[1:3] !(|(sink_en & above_short_threshold)))
    else $error("shorted sink kept on");
  a_fault_latched: assert property (fault_line_oe && enable_in && $past(enable_in) && dim_in && $past(dim_in)
    |=> fault_line_oe)
    else $error("fault released early");
  a_detect_gated: assert property (!fault_line_oe && at_regulation == '0 |=> !fault_line_oe)
    else $error("short seen with no pin in regulation");
endmodule
`default_nettype wire

// [testbench/lfl_top_tb.sv]
// self-checking bench for the fault latch and shutdown block
`default_nettype none
module lfl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOWC = 50;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        enable_in = 1'h0;
  logic        dim_in = 1'h0;
  logic [3:0]  above_short_threshold = 4'h0;
  logic [3:0]  at_regulation = 4'h0;
  logic        fault_line_in;
  logic        fault_line_out;
  logic        fault_line_oe;
  logic        bias_on;
  logic        sync_clock_output_en;
  logic        boost_en;
  logic [3:0]  sink_en;
  logic        irq;
  logic        peer_pull = 1'h0;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          checked = 0;
  int          seed = 32'h3746766C;
  int          ch;
  int          exp_sink;
  lfl_top #(.LOW_CYCLES(LOWC), .SOFT_CYCLES(4)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .enable_in, .dim_in, .above_short_threshold,
    .at_regulation, .fault_line_in, .fault_line_out, .fault_line_oe, .bias_on,
    .sync_clock_output_en, .boost_en, .sink_en, .irq);
  lfl_peer_model i_peer (.dut_pull(fault_line_oe), .peer_pull(peer_pull), .line(fault_line_in));
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // holds the request until pready; one idle edge after so psel never toggles twice at once
  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    cyc(2);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", rd & 32'hF, 32'h1);
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    chk("rdata", rd, 32'h0);
    apb(1'h1, 12'h00C, 32'h1);
    $display("test regs done");
    enable_in <= 1'h1;
    cyc(3);
    chk("bias", {31'h0, bias_on}, 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", rd & 32'hF, 32'h2);
    dim_in <= 1'h1;
    cyc(2);
    chk("sink", {28'h0, sink_en}, 32'h0);
    cyc(8);
    chk("sink", {28'h0, sink_en}, 32'hF);
    $display("test wake done");
    ch = $random(seed) & 3;
    exp_sink = 4'hF & ~(1 << ch);
    above_short_threshold <= 4'h1 << ch;
    cyc(5);
    chk("fault", {31'h0, fault_line_oe}, 32'h0);
    at_regulation <= 4'hF;
    cyc(4);
    chk("fault", {31'h0, fault_line_oe}, 32'h1);
    chk("sink", {28'h0, sink_en}, exp_sink);
    chk("irq", {31'h0, irq}, 32'h1);
    above_short_threshold <= 4'h0;
    apb(1'h1, 12'h008, 32'h1);
    cyc(2);
    chk("irq", {31'h0, irq}, 32'h0);
    dim_in <= 1'h0;
    cyc(LOWC - 20);
    dim_in <= 1'h1;
    cyc(3);
    chk("fault", {31'h0, fault_line_oe}, 32'h1);
    dim_in <= 1'h0;
    cyc(LOWC + 10);
    chk("fault", {31'h0, fault_line_oe}, 32'h0);
    chk("bias", {31'h0, sync_clock_output_en}, 32'h1);
    dim_in <= 1'h1;
    cyc(10);
    chk("sink", {28'h0, sink_en}, 32'hF);
    $display("test short done");
    apb(1'h1, 12'h000, 32'h1);
    // eight low cycles is the longest hold that must be ignored
    peer_pull <= 1'h1;
    cyc(8);
    peer_pull <= 1'h0;
    cyc(3);
    chk("boost", {31'h0, boost_en}, 32'h1);
    peer_pull <= 1'h1;
    cyc(12);
    chk("boost", {31'h0, boost_en}, 32'h0);
    chk("sink", {28'h0, sink_en}, 32'h0);
    peer_pull <= 1'h0;
    $display("test line done");
    above_short_threshold <= 4'h1;
    dim_in <= 1'h0;
    cyc(LOWC + 10);
    dim_in <= 1'h1;
    cyc(12);
    chk("fault", {31'h0, fault_line_oe}, 32'h1);
    chk("sink", {28'h0, sink_en}, 32'h0);
    above_short_threshold <= 4'h0;
    $display("test alloff done");
    enable_in <= 1'h0;
    cyc(LOWC - 20);
    chk("bias", {31'h0, bias_on}, 32'h1);
    enable_in <= 1'h1;
    cyc(3);
    chk("bias", {31'h0, bias_on}, 32'h1);
    enable_in <= 1'h0;
    cyc(LOWC + 10);
    chk("bias", {31'h0, bias_on}, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", rd & 32'hF, 32'h1);
    chk("fault", {31'h0, fault_line_oe}, 32'h1);
    enable_in <= 1'h1;
    cyc(3);
    chk("fault", {31'h0, fault_line_oe}, 32'h0);
    $display("test sleep done");
    give_verdict();
  end
endmodule
bind lfl_top lfl_top_sva #(.CHANNELS(CHANNELS), .LOW_CYCLES(LOW_CYCLES)) i_sva (.pclk, .presetn,
  .enable_in, .dim_in, .above_short_threshold, .at_regulation, .fault_line_out, .fault_line_oe,
  .bias_on, .sync_clock_output_en, .boost_en, .sink_en);
`default_nettype wire
